/* logic/edc_pkg.sv */
package edc_pkg;
    localparam int BEAT_W      = 64;
    localparam int LINE_W      = 128;
    localparam int CHK_W       = 8;
    localparam int HALF_W      = BEAT_W + CHK_W;
    localparam int ARRAY_W     = 2 * HALF_W;
    localparam int MOD_W       = 36;
    localparam int GROUPS      = 4;
    localparam int MODS_PER_GR = 4;
    localparam int ADDR_W      = 36;
    localparam int LINE_ADDR_W = 23;
    localparam int UNIT_LSB    = 24;
    localparam int UNIT_W      = 12;
    localparam int OFS_W       = 3;
    localparam int TOTAL_UNITS = 32;
    localparam int BUS_MHZ     = 40;

    localparam logic [2:0] SIZE_DWORD = 3'h3;
    localparam logic [3:0] IRQ_CE_LEVEL = 4'hf;

    typedef enum logic [2:0] {
        GRP_EMPTY   = 3'h0,
        GRP_4M_SS   = 3'h1,
        GRP_4M_DS   = 3'h2,
        GRP_16M_SS  = 3'h3,
        GRP_16M_DS  = 3'h4
    } edc_grp_t;

    typedef enum logic [3:0] {
        TT_WRITE    = 4'h0,
        TT_READ     = 4'h1,
        TT_CRD      = 4'h2,
        TT_CRI      = 4'h3,
        TT_CWI      = 4'h4,
        TT_CINV     = 4'h5
    } edc_type_t;

    // Group capacity in 16 MByte units
    function automatic logic [3:0] edc_grp_units(input edc_grp_t g);
        unique case (g)
            GRP_4M_SS:  return 4'h1;
            GRP_4M_DS:  return 4'h2;
            GRP_16M_SS: return 4'h4;
            GRP_16M_DS: return 4'h8;
            default:    return 4'h0;
        endcase
    endfunction : edc_grp_units
endpackage : edc_pkg

/* logic/edc_ecc.sv */
`timescale 1ns/1ns
module edc_ecc
    import edc_pkg::*;
(
    input  wire logic [edc_pkg::BEAT_W-1:0] data,
    input  wire logic [edc_pkg::CHK_W-1:0]  check_in,
    output logic      [edc_pkg::CHK_W-1:0]  check_gen,
    output logic      [edc_pkg::BEAT_W-1:0] corrected,
    output logic      [edc_pkg::CHK_W-1:0]  syndrome,
    output logic                            single_err,
    output logic                            multi_err
);
    // Nibbles 0 to 13: weight-5 columns from one 4-set each, so three bad bits in a nibble give weight 7.
    // Nibbles 14 and 15: weight-3 columns whose nibble triples fall on unused codes
    function automatic logic [CHK_W-1:0] col(input int idx);
        logic [CHK_W-1:0] tail [8];
        logic [2:0]       x;
        int               n;
        int               k;
        tail = '{8'h07, 8'h19, 8'h61, 8'h2a, 8'h0e, 8'h32, 8'hc2, 8'h54};
        col = (idx >= 56) ? tail[idx - 56] : '0;
        n = 0;
        for (int v = 0; v < 256; v++) begin
            x = 3'h0;
            for (int b = 0; b < 8; b++) begin
                x = v[b] ? x ^ 3'(b) : x;
            end
            if ($countones(v[7:0]) == 4 && x == 3'h0) begin
                k = 0;
                for (int b = 0; b < 8; b++) begin
                    if (v[b] && n == idx / 4 && k == idx % 4) begin
                        col = ~(v[7:0] ^ (8'h1 << b));
                    end
                    k = v[b] ? k + 1 : k;
                end
                n++;
            end
        end
    endfunction : col

    logic [BEAT_W-1:0] flip;
    logic              hit;
    logic [CHK_W-1:0]  cols [BEAT_W];

    // Columns are fixed, so they are worked out once instead of on every data change
    for (genvar i = 0; i < BEAT_W; i++) begin : g_cols
        assign cols[i] = col(i);
    end

    always_comb begin
        check_gen = '0;
        for (int i = 0; i < BEAT_W; i++) begin
            if (data[i]) begin
                check_gen = check_gen ^ cols[i];
            end
        end
        syndrome = check_gen ^ check_in;
        flip = '0;
        hit = 1'b0;
        for (int i = 0; i < BEAT_W; i++) begin
            if (syndrome == cols[i]) begin
                flip[i] = 1'b1;
                hit = 1'b1;
            end
        end
        // Odd weight on a data column or a single check bit: one flipped bit; even weight or other odd pattern: detected only
        single_err = (syndrome != '0) && ($countones(syndrome) % 2 == 1)
                     && (hit || $countones(syndrome) == 1);
        multi_err  = (syndrome != '0) && !single_err;
        corrected  = data ^ flip;
    end
endmodule : edc_ecc

/* logic/edc_ctrl.sv */
`timescale 1ns/1ns
// Overview of operation
// - Writes narrower than a doubleword read the line, merge the new bytes and rewrite with new check bits.
// - A read with one bad bit returns corrected data with a normal acknowledge.
// - An access with two bad bits, or a pattern the code cannot place, ends that cycle with an error acknowledge instead.
// - Each corrected error can raise a level 15 interrupt request to the processors.
// - The code corrects one bad bit, detects two, and flags patterns it cannot place as uncorrectable.
// - Data moves to and from the array over a 144-bit path, two checked doublewords per line.
// - Every transaction size and both plain and coherent transaction types are accepted.
// - A single or multi-bit error is captured with address and syndrome while none is held; later ones set overflow, a multi-bit replacing a held single.
// - Sixteen 36-bit modules form four groups of four, one group per 144-bit line access.
// - Each group is set to 4Mbit or 16Mbit parts, single or double sided, by its own setting.
// - Capacity runs from 16 to 512 MBytes, groups stacked in address order.
// - The block runs on the 40MHz system bus clock and answers as a level two slave.
module edc_ctrl
    import edc_pkg::*;
#(
    parameter int NGROUPS = edc_pkg::GROUPS
) (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire edc_pkg::edc_grp_t               grp_cfg [NGROUPS],
    input  wire logic                            ce_irq_enable,
    input  wire logic                            err_clear,
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire logic [3:0]                      req_type,
    input  wire logic [2:0]                      req_size,
    input  wire logic [edc_pkg::ADDR_W-1:0]      req_addr,
    input  wire logic [edc_pkg::BEAT_W-1:0]      req_wdata,
    output logic                                 rsp_ack,
    output logic                                 rsp_err,
    output logic      [edc_pkg::BEAT_W-1:0]      rsp_rdata,
    output logic                                 mem_valid,
    input  wire logic                            mem_ready,
    output logic                                 mem_write,
    output logic      [1:0]                      mem_we,
    output logic      [1:0]                      mem_group,
    output logic      [edc_pkg::LINE_ADDR_W-1:0] mem_line,
    output logic      [edc_pkg::ARRAY_W-1:0]     mem_wdata,
    input  wire logic                            mem_rvalid,
    input  wire logic [edc_pkg::ARRAY_W-1:0]     mem_rdata,
    output logic      [3:0]                      irq_level,
    output logic                                 err_valid,
    output logic                                 err_multi,
    output logic                                 err_overflow,
    output logic      [edc_pkg::ADDR_W-1:0]      err_addr,
    output logic      [edc_pkg::CHK_W-1:0]       err_syndrome
);
    import edc_pkg::*;

    if (NGROUPS < 1 || NGROUPS > GROUPS) begin : bad_groups
        $error("NGROUPS must be 1 to 4");
    end

    typedef enum logic [5:0] {
        S_IDLE    = 6'b000001,
        S_RD_REQ  = 6'b000010,
        S_RD_WAIT = 6'b000100,
        S_WR_REQ  = 6'b001000,
        S_BEAT    = 6'b010000,
        S_DONE    = 6'b100000
    } edc_state_t;

    function automatic logic is_write(input logic [3:0] t);
        return (t == TT_WRITE) || (t == TT_CWI);
    endfunction : is_write

    function automatic logic [7:0] byte_mask(input logic [2:0] size, input logic [2:0] ofs);
        logic [7:0] m;
        unique case (size)
            3'h0:    m = 8'h01;
            3'h1:    m = 8'h03;
            3'h2:    m = 8'h0f;
            default: m = 8'hff;
        endcase
        return 8'(m << ofs);
    endfunction : byte_mask

    // Groups stack upward from zero in group order
    function automatic logic [5:0] decode(input logic [ADDR_W-1:0] a, input edc_grp_t cfg [NGROUPS]);
        logic [5:0]        res;
        logic [UNIT_W-1:0] base;
        logic [UNIT_W-1:0] units;
        res = '0;
        base = '0;
        for (int g = 0; g < NGROUPS; g++) begin
            units = UNIT_W'(edc_grp_units(cfg[g]));
            if (!res[5] && a[ADDR_W-1:UNIT_LSB] >= base && a[ADDR_W-1:UNIT_LSB] < base + units) begin
                res = {1'b1, 2'(g), OFS_W'(a[ADDR_W-1:UNIT_LSB] - base)};
            end
            base = base + units;
        end
        return res;
    endfunction : decode

    edc_state_t          state, next_state;
    logic [3:0]          ttype, next_ttype;
    logic [2:0]          tsize, next_tsize;
    logic [ADDR_W-1:0]   taddr, next_taddr;
    logic [4:0]          beats, next_beats;
    logic [BEAT_W-1:0]   wbuf, next_wbuf;
    logic                next_ack, next_err;
    logic [BEAT_W-1:0]   next_rdata;
    logic [1:0]          next_mem_we, next_mem_group;
    logic [LINE_ADDR_W-1:0] next_mem_line;
    logic [ARRAY_W-1:0]  next_mem_wdata;
    logic [5:0]          dec;
    logic                half;
    logic [BEAT_W-1:0]   enc_data;
    logic [CHK_W-1:0]    enc_chk;
    logic [BEAT_W-1:0]   dec_data, dec_fixed;
    logic [CHK_W-1:0]    dec_chk, dec_syn;
    logic                dec_single, dec_multi;
    logic [7:0]          mask;
    logic                ev_single, ev_multi;

    assign half = taddr[3];
    assign mask = byte_mask(tsize, taddr[2:0]);
    assign dec  = decode(req_valid && state == S_IDLE ? req_addr : taddr, grp_cfg);
    assign dec_data = half ? mem_rdata[HALF_W+BEAT_W-1:HALF_W] : mem_rdata[BEAT_W-1:0];
    assign dec_chk  = half ? mem_rdata[ARRAY_W-1:HALF_W+BEAT_W] : mem_rdata[HALF_W-1:BEAT_W];

    // Only the addressed doubleword of the 128-bit line is checked and rewritten
    edc_ecc u_dec (
        .data       (dec_data),
        .check_in   (dec_chk),
        .check_gen  (),
        .corrected  (dec_fixed),
        .syndrome   (dec_syn),
        .single_err (dec_single),
        .multi_err  (dec_multi)
    );

    edc_ecc u_enc (
        .data       (enc_data),
        .check_in   ('0),
        .check_gen  (enc_chk),
        .corrected  (),
        .syndrome   (),
        .single_err (),
        .multi_err  ()
    );

    assign ev_single = (state == S_RD_WAIT) && mem_rvalid && dec_single;
    assign ev_multi  = (state == S_RD_WAIT) && mem_rvalid && dec_multi;

    assign req_ready = (state == S_IDLE);
    assign mem_valid = (state == S_RD_REQ) || (state == S_WR_REQ);
    assign mem_write = (state == S_WR_REQ);

    always_comb begin
        next_state     = state;
        next_ttype     = ttype;
        next_tsize     = tsize;
        next_taddr     = taddr;
        next_beats     = beats;
        next_wbuf      = wbuf;
        next_ack       = 1'b0;
        next_err       = 1'b0;
        next_rdata     = rsp_rdata;
        next_mem_we    = mem_we;
        next_mem_group = mem_group;
        next_mem_line  = mem_line;
        enc_data       = wbuf;
        unique case (state)
            S_IDLE: begin
                enc_data = req_wdata;
                if (req_valid) begin
                    // Any size and any plain or coherent type is taken
                    next_ttype = req_type;
                    next_tsize = req_size;
                    next_taddr = req_addr;
                    next_wbuf  = req_wdata;
                    next_beats = (req_size > SIZE_DWORD) ? 5'(5'h1 << (req_size - SIZE_DWORD)) : 5'h1;
                    next_mem_group = dec[4:3];
                    next_mem_line  = {dec[2:0], req_addr[UNIT_LSB-1:4]};
                    next_mem_we    = req_addr[3] ? 2'b10 : 2'b01;
                    if (!dec[5]) begin
                        next_err   = 1'b1;
                        next_state = S_DONE;
                    end else if (req_type == TT_CINV) begin
                        next_ack   = 1'b1;
                        next_state = S_DONE;
                    end else if (is_write(req_type) && req_size >= SIZE_DWORD) begin
                        next_state = S_WR_REQ;
                    end else begin
                        next_state = S_RD_REQ;
                    end
                end
            end
            S_RD_REQ: begin
                if (mem_ready) begin
                    next_state = S_RD_WAIT;
                end
            end
            S_RD_WAIT: begin
                for (int b = 0; b < 8; b++) begin
                    enc_data[8*b +: 8] = mask[b] ? wbuf[8*b +: 8] : dec_fixed[8*b +: 8];
                end
                if (mem_rvalid) begin
                    if (dec_multi) begin
                        next_err   = 1'b1;
                        next_state = S_DONE;
                    end else if (is_write(ttype)) begin
                        next_wbuf  = enc_data;
                        next_state = S_WR_REQ;
                    end else begin
                        next_rdata = dec_fixed;
                        next_ack   = 1'b1;
                        next_beats = beats - 5'h1;
                        next_taddr = taddr + ADDR_W'(8);
                        next_state = (beats == 5'h1) ? S_DONE : S_BEAT;
                    end
                end
            end
            S_WR_REQ: begin
                if (mem_ready) begin
                    next_ack   = 1'b1;
                    next_beats = beats - 5'h1;
                    next_taddr = taddr + ADDR_W'(8);
                    next_state = (beats == 5'h1) ? S_DONE : S_BEAT;
                end
            end
            S_BEAT: begin
                // Master puts the next write beat up in the same cycle as each ack
                enc_data       = req_wdata;
                next_wbuf      = req_wdata;
                next_mem_group = dec[4:3];
                next_mem_line  = {dec[2:0], taddr[UNIT_LSB-1:4]};
                next_mem_we    = taddr[3] ? 2'b10 : 2'b01;
                if (!dec[5]) begin
                    next_err   = 1'b1;
                    next_state = S_DONE;
                end else begin
                    next_state = is_write(ttype) ? S_WR_REQ : S_RD_REQ;
                end
            end
            S_DONE: begin
                next_state = S_IDLE;
            end
        endcase
        // Fresh check bits go with every line write, same code in both halves' lanes
        next_mem_wdata = {enc_chk, enc_data, enc_chk, enc_data};
        if (state == S_WR_REQ) begin
            next_mem_wdata = mem_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            ttype     <= 4'h0;
            tsize     <= 3'h0;
            taddr     <= '0;
            beats     <= 5'h0;
            wbuf      <= '0;
            rsp_ack   <= 1'b0;
            rsp_err   <= 1'b0;
            rsp_rdata <= '0;
            mem_we    <= 2'b00;
            mem_group <= 2'h0;
            mem_line  <= '0;
            mem_wdata <= '0;
        end else begin
            state     <= next_state;
            ttype     <= next_ttype;
            tsize     <= next_tsize;
            taddr     <= next_taddr;
            beats     <= next_beats;
            wbuf      <= next_wbuf;
            rsp_ack   <= next_ack;
            rsp_err   <= next_err;
            rsp_rdata <= next_rdata;
            mem_we    <= next_mem_we;
            mem_group <= next_mem_group;
            mem_line  <= next_mem_line;
            mem_wdata <= next_mem_wdata;
        end
    end

    logic                next_valid, next_multi, next_ovf;
    logic [ADDR_W-1:0]   next_eaddr;
    logic [CHK_W-1:0]    next_esyn;
    logic [3:0]          next_irq;

    always_comb begin
        next_valid = err_valid;
        next_multi = err_multi;
        next_ovf   = err_overflow;
        next_eaddr = err_addr;
        next_esyn  = err_syndrome;
        if (err_clear) begin
            next_valid = 1'b0;
            next_multi = 1'b0;
            next_ovf   = 1'b0;
        end
        // A new event wins over a clear in the same cycle; a multi-bit event replaces a held single
        if (ev_single || ev_multi) begin
            if (err_valid && !err_clear && !(ev_multi && !err_multi)) begin
                next_ovf = 1'b1;
            end else begin
                next_valid = 1'b1;
                next_multi = ev_multi;
                next_eaddr = taddr;
                next_esyn  = dec_syn;
                next_ovf   = err_valid && !err_clear;
            end
        end
        // Held corrected error raises level 15 only while enabled
        next_irq = (ce_irq_enable && next_valid && !next_multi) ? IRQ_CE_LEVEL : 4'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_valid    <= 1'b0;
            err_multi    <= 1'b0;
            err_overflow <= 1'b0;
            err_addr     <= '0;
            err_syndrome <= '0;
            irq_level    <= 4'h0;
        end else begin
            err_valid    <= next_valid;
            err_multi    <= next_multi;
            err_overflow <= next_ovf;
            err_addr     <= next_eaddr;
            err_syndrome <= next_esyn;
            irq_level    <= next_irq;
        end
    end

    ack_err_excl_a: assert property (@(posedge clk) disable iff (!rst_n) !(rsp_ack && rsp_err))
        else $error("ack and error ack together");
    single_fix_a: assert property (@(posedge clk) disable iff (!rst_n)
        ev_single && !is_write(ttype) |=> rsp_ack && !rsp_err && rsp_rdata == $past(dec_fixed))
        else $error("bad corrected read");
    multi_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        ev_multi |=> rsp_err ##1 state == S_IDLE && !mem_valid)
        else $error("no error ack");
    narrow_rmw_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_IDLE && req_valid && dec[5] && is_write(req_type) && req_size < SIZE_DWORD
        |=> state == S_RD_REQ && !mem_write)
        else $error("no read before merge");
    capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ev_single || ev_multi) |=> err_valid && (err_multi || !$past(ev_multi)))
        else $error("error not captured");
    hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        err_valid && !err_clear |=> err_valid && (err_addr == $past(err_addr) || err_multi && !$past(err_multi)))
        else $error("capture lost");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_level == IRQ_CE_LEVEL |-> $past(ce_irq_enable) && err_valid && !err_multi)
        else $error("stray interrupt");
    unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == S_IDLE && req_valid && !dec[5] |=> rsp_err ##1 state == S_IDLE)
        else $error("unpopulated address not refused");
endmodule : edc_ctrl

/* bench/edc_mem_model.sv */
`timescale 1ns/1ns
module edc_mem_model
    import edc_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic                            slow,
    input  wire logic [edc_pkg::ARRAY_W-1:0]     flip_mask,
    input  wire logic                            mem_valid,
    output logic                                 mem_ready,
    input  wire logic                            mem_write,
    input  wire logic [1:0]                      mem_we,
    input  wire logic [1:0]                      mem_group,
    input  wire logic [edc_pkg::LINE_ADDR_W-1:0] mem_line,
    input  wire logic [edc_pkg::ARRAY_W-1:0]     mem_wdata,
    output logic                                 mem_rvalid,
    output logic      [edc_pkg::ARRAY_W-1:0]     mem_rdata
);
    logic [edc_pkg::ARRAY_W-1:0] store [logic [24:0]];
    logic [edc_pkg::ARRAY_W-1:0] line;
    logic [edc_pkg::ARRAY_W-1:0] rd_line;
    int                          wait_cnt;
    int                          lat;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= '0;
            wait_cnt   <= 0;
            lat        <= 0;
        end else begin
            mem_rvalid <= 1'b0;
            // Idle data keeps toggling so stale values never pass as read data
            mem_rdata  <= ~mem_rdata;
            if (lat == 1) begin
                mem_rvalid <= 1'b1;
                mem_rdata  <= rd_line ^ flip_mask;
            end
            if (lat > 0)
                lat <= lat - 1;
            wait_cnt  <= mem_valid ? wait_cnt + 1 : 0;
            mem_ready <= !slow || (mem_valid && wait_cnt >= 2);
            if (mem_valid && mem_ready) begin
                wait_cnt  <= 0;
                mem_ready <= !slow;
                line = store.exists({mem_group, mem_line}) ? store[{mem_group, mem_line}] : '1;
                if (mem_write) begin
                    // Half enables
                    if (mem_we[0])
                        line[71:0] = mem_wdata[71:0];
                    if (mem_we[1])
                        line[143:72] = mem_wdata[143:72];
                    store[{mem_group, mem_line}] = line;
                end else begin
                    rd_line = line;
                    lat <= slow ? 3 : 1;
                end
            end
        end
    end
endmodule : edc_mem_model

/* bench/test_edc_ctrl.sv */
`timescale 1ns/1ns
module test_edc_ctrl;
    import edc_pkg::*;
    logic         clk, rst_n, ce_irq_enable, err_clear, req_valid, req_ready, rsp_ack, rsp_err, slow;
    logic         mem_valid, mem_ready, mem_write, mem_rvalid, err_valid, err_multi, err_overflow;
    edc_grp_t     grp_cfg [4];
    logic [3:0]   req_type, irq_level;
    logic [2:0]   req_size;
    logic [35:0]  req_addr, err_addr;
    logic [63:0]  req_wdata, rsp_rdata;
    logic [1:0]   mem_we, mem_group;
    logic [22:0]  mem_line;
    logic [143:0] mem_wdata, mem_rdata, flip_mask;
    logic [7:0]   err_syndrome;
    int           bad_count, n_compared;
    logic [63:0]  rq [$];

    edc_ctrl #(.NGROUPS(4)) edc_ctrl_inst (.*);
    edc_mem_model edc_mem_model_inst (.*);

    // Bus clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [143:0] halves(input logic [63:0] m);
        return {8'h00, m, 8'h00, m};
    endfunction : halves

    // One transaction from a falling edge; read beats land in rq
    task automatic xfer(input logic [3:0] t, input logic [2:0] s, input logic [35:0] a,
                        input logic [63:0] wd, output logic err);
        int nb;
        int i;
        err = 1'b0;
        nb = (s > 3'h3) ? (1 << (s - 3'h3)) : 1;
        rq.delete();
        {req_valid, req_type, req_size, req_addr, req_wdata} = {1'b1, t, s, a, wd};
        for (i = 0; i < 100 && !req_ready; i++)
            @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 300 && rq.size() < nb && !err; i++) begin
            err = rsp_err;
            if (rsp_ack) begin
                rq.push_back(rsp_rdata);
                req_wdata = wd + 64'(rq.size());
            end
            if (rq.size() < nb && !err)
                @(negedge clk);
        end
        if (!err)
            check(64'(rq.size()), 64'(nb));
    endtask : xfer

    task automatic t_basic;
        logic e;
        xfer(TT_WRITE, 3'h3, 36'h100, 64'h0123456789abcdef, e);
        xfer(TT_WRITE, 3'h3, 36'h108, 64'hfedcba9876543210, e);
        xfer(TT_READ, 3'h4, 36'h100, '0, e);
        check(rq[0], 64'h0123456789abcdef);
        check(rq[1], 64'hfedcba9876543210);
        check(64'(err_valid), 64'h0);
    endtask : t_basic

    task automatic t_bursts;
        logic e;
        slow = 1'b1;
        xfer(TT_WRITE, 3'h6, 36'h200, 64'h1111000000000000, e);
        xfer(TT_CRD, 3'h6, 36'h200, '0, e);
        for (int i = 0; i < 8; i++)
            check(rq[i], 64'h1111000000000000 + 64'(i));
        xfer(TT_CWI, 3'h3, 36'h240, 64'h2222333344445555, e);
        xfer(TT_CRI, 3'h3, 36'h240, '0, e);
        check(rq[0], 64'h2222333344445555);
        xfer(TT_CINV, 3'h3, 36'h240, '0, e);
        check(64'(e), 64'h0);
        slow = 1'b0;
    endtask : t_bursts

    task automatic t_narrow;
        logic e;
        slow = 1'b1;
        xfer(TT_WRITE, 3'h3, 36'h300, 64'h8877665544332211, e);
        xfer(TT_WRITE, 3'h3, 36'h308, 64'h5a5a5a5a5a5a5a5a, e);
        xfer(TT_WRITE, 3'h0, 36'h303, 64'h00000000aa000000, e);
        xfer(TT_WRITE, 3'h1, 36'h306, 64'hbbcc000000000000, e);
        xfer(TT_READ, 3'h3, 36'h300, '0, e);
        check(rq[0], 64'hbbcc6655aa332211);
        xfer(TT_WRITE, 3'h2, 36'h304, 64'h1234567800000000, e);
        xfer(TT_READ, 3'h4, 36'h300, '0, e);
        check(rq[0], 64'h12345678aa332211);
        check(rq[1], 64'h5a5a5a5a5a5a5a5a);
        slow = 1'b0;
    endtask : t_narrow

    task automatic t_single;
        logic e;
        ce_irq_enable = 1'b1;
        flip_mask = halves(64'h20);
        xfer(TT_READ, 3'h3, 36'h100, '0, e);
        check(64'(e), 64'h0);
        check(rq[0], 64'h0123456789abcdef);
        @(negedge clk);
        check({err_valid, err_multi, err_overflow}, 64'h4);
        check(64'(err_addr), 64'h100);
        check(64'(err_syndrome != 8'h00), 64'h1);
        check(64'(irq_level), 64'hf);
        ce_irq_enable = 1'b0;
        repeat (2) @(negedge clk);
        check(64'(irq_level), 64'h0);
        ce_irq_enable = 1'b1;
        xfer(TT_READ, 3'h3, 36'h100, '0, e);
        @(negedge clk);
        check({err_valid, err_overflow, irq_level}, 64'h3f);
        err_clear = 1'b1;
        @(negedge clk);
        err_clear = 1'b0;
        @(negedge clk);
        check({err_valid, err_overflow, irq_level}, 64'h0);
    endtask : t_single

    task automatic t_multi;
        logic        e;
        logic [63:0] masks [3];
        masks = '{64'h0000010000000200, 64'h7, 64'hf0};
        for (int i = 0; i < 3; i++) begin
            flip_mask = (i == 0) ? halves(64'h1) : '0;
            xfer(TT_READ, 3'h3, 36'h100, '0, e);
            flip_mask = halves(masks[i]);
            xfer(TT_READ, 3'h3, 36'h100, '0, e);
            check(64'(e), 64'h1);
            @(negedge clk);
            check({err_valid, err_multi}, 64'h3);
            err_clear = 1'b1;
            @(negedge clk);
            err_clear = 1'b0;
        end
        flip_mask = halves(masks[0]);
        xfer(TT_WRITE, 3'h0, 36'h100, 64'hff, e);
        check(64'(e), 64'h1);
        flip_mask = '0;
        xfer(TT_READ, 3'h3, 36'h100, '0, e);
        check(rq[0], 64'h0123456789abcdef);
        err_clear = 1'b1;
        @(negedge clk);
        err_clear = 1'b0;
    endtask : t_multi

    task automatic t_map;
        logic        e;
        logic [35:0] top;
        for (int g = 1; g < 6; g++) begin
            grp_cfg[0] = (g == 5) ? GRP_16M_DS : edc_grp_t'(g);
            for (int k = 1; k < 4; k++)
                grp_cfg[k] = (g == 5) ? GRP_16M_DS : GRP_EMPTY;
            top = 36'h1000000 << ((g == 5) ? 5 : g - 1);
            xfer(TT_WRITE, 3'h3, top - 36'h8, 64'(g), e);
            xfer(TT_READ, 3'h3, top - 36'h8, '0, e);
            check(rq[0], 64'(g));
            xfer(TT_READ, 3'h3, top, '0, e);
            check(64'(e), 64'h1);
        end
    endtask : t_map

    initial begin
        #100000;
        bad_count++;
        complete_run();
    end

    initial begin
        bad_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        grp_cfg = '{GRP_4M_SS, GRP_16M_DS, GRP_EMPTY, GRP_EMPTY};
        ce_irq_enable = 1'b0;
        err_clear = 1'b0;
        req_valid = 1'b0;
        req_type = '0;
        req_size = '0;
        req_addr = '0;
        req_wdata = '0;
        slow = 1'b0;
        flip_mask = '0;
        repeat (8) @(negedge clk);
        check({req_ready, rsp_ack, rsp_err, irq_level, err_valid}, 64'h80);
        rst_n = 1'b1;
        t_basic();
        t_bursts();
        t_narrow();
        t_single();
        t_multi();
        t_map();
        complete_run();
    end
endmodule : test_edc_ctrl
